/* File: hdl/alarm_relay_control.v */
// Alarm relay control: configuration menu, relay drive, fault terminal, auto calibration, Wishbone registers
//
// Behaviour
// [R01] Auto-reset relay releases by itself once reading falls under its threshold.
// [R02] Latching relay stays on after trip until operator reset.
// [R03] After reset both relays are in auto-reset mode.
// [R04] Auto-reset release needs reading 10 percent below the set-point.
// [R05] Operator reset of a latched alarm ignored unless reading under set-point.
// [R06] Alarm activation inhibited for one minute after leaving the menu.
// [R07] Menu button held six seconds in normal operation opens the menu.
// [R08] On latch-mode screens, either add or sub toggles latch versus auto-reset.
// [R09] Menu press on relay 1 latch screen commits and moves to relay 2.
// [R10] Fail-safe enabled inverts relay drive; de-energised means hazard.
// [R11] Fail-safe relay energised at start-up, de-energised during alarm.
// [R12] Per-relay fail-safe enable chosen with add/sub, both default off.
// [R13] Fault terminal polarity selectable; default de-asserts during a fault.
// [R14] Calibration screen: add selects manual, sub automatic; manual by default.
// [R15] Automatic calibration forces reading to stored target after fixed delay.
// [R16] Short menu press in normal mode is the operator reset.
// [R17] Five minutes without button activity returns the menu to normal mode.
// [R18] Relay 1 uses set-point 1, relay 2 set-point 2; trip at or above.
// [R19] Fault fail-safe yes de-asserts output on fault, no asserts it.
`timescale 1ns/100ps
`include "alarm_defs.vh"

module alarm_relay_control #(
    parameter [39:0] INHIBIT_CYCLES    = `INHIBIT_CYCLES,
    parameter [39:0] LONG_PRESS_CYCLES = `LONG_PRESS_CYCLES,
    parameter [39:0] IDLE_CYCLES       = `IDLE_CYCLES,
    parameter [39:0] AUTOCAL_CYCLES    = `AUTOCAL_CYCLES
) (
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire [15:0] gas_reading_i,
    input  wire [15:0] setpoint1_i,
    input  wire [15:0] setpoint2_i,
    input  wire        add_btn_i,
    input  wire        sub_btn_i,
    input  wire        menu_btn_i,
    input  wire        fault_i,
    input  wire        cal_active_i,
    output wire        relay1_o,
    output wire        relay2_o,
    output reg         fault_term_o,
    output reg         cal_force_o,
    output reg  [15:0] cal_value_o,
    output reg         menu_active_o,
    output reg         irq_o,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [5:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o
);

    // ----------------------------------------------------------------
    // Screens
    // ----------------------------------------------------------------
    localparam [2:0] S_NORMAL   = 3'h0;
    localparam [2:0] S_LATCH1   = 3'h1;
    localparam [2:0] S_LATCH2   = 3'h2;
    localparam [2:0] S_FS1      = 3'h3;
    localparam [2:0] S_FS2      = 3'h4;
    localparam [2:0] S_FAULT_FS = 3'h5;
    localparam [2:0] S_CAL      = 3'h6;

    reg  [2:0]           screen;
    reg  [2:0]           next_screen;
    reg                  add_prev;
    reg                  sub_prev;
    reg                  menu_prev;
    reg                  fault_prev;
    reg  [39:0]          press_count;
    reg                  press_used;
    reg  [39:0]          idle_count;
    reg  [39:0]          inhibit_count;
    reg  [39:0]          cal_count;
    reg                  op_reset;
    reg  [`CFG_WIDTH-1:0] config_bits;
    reg  [15:0]          cal_target;
    reg  [`EV_WIDTH-1:0] irq_status;
    reg  [`EV_WIDTH-1:0] irq_enable;
    reg                  alarm1_prev;
    reg                  alarm2_prev;
    reg                  cal_force_prev;

    wire                 add_edge;
    wire                 sub_edge;
    wire                 menu_edge;
    wire                 menu_release;
    wire                 any_edge;
    wire                 in_menu;
    wire                 long_press;
    wire                 idle_timeout;
    wire                 menu_exit;
    wire                 inhibit;
    wire                 alarm1;
    wire                 alarm2;
    wire                 bus_req;
    wire                 bus_write;
    wire [`EV_WIDTH-1:0] events;

    // ----------------------------------------------------------------
    // Button edges
    // ----------------------------------------------------------------
    assign add_edge     = add_btn_i & ~add_prev;
    assign sub_edge     = sub_btn_i & ~sub_prev;
    assign menu_edge    = menu_btn_i & ~menu_prev;
    assign menu_release = ~menu_btn_i & menu_prev;
    assign any_edge     = add_edge | sub_edge | menu_edge;
    assign in_menu      = (screen != S_NORMAL);

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            add_prev  <= 1'b0;
            sub_prev  <= 1'b0;
            menu_prev <= 1'b0;
        end else begin
            add_prev  <= add_btn_i;
            sub_prev  <= sub_btn_i;
            menu_prev <= menu_btn_i;
        end
    end

    // ----------------------------------------------------------------
    // Long press and operator reset
    // ----------------------------------------------------------------
    assign long_press = !in_menu && menu_btn_i && !press_used
                        && (press_count >= LONG_PRESS_CYCLES - 40'd1);   // [R07]

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            press_count <= 40'h0;
            press_used  <= 1'b0;
            op_reset    <= 1'b0;
        end else begin
            op_reset <= 1'b0;
            if (!menu_btn_i) begin
                press_count <= 40'h0;
                press_used  <= 1'b0;
                // Release before the hold time counts as a single press
                if (menu_release && !press_used && !in_menu) begin
                    op_reset <= 1'b1;                                     // [R16]
                end
            end else begin
                if (press_count != LONG_PRESS_CYCLES) begin
                    press_count <= press_count + 40'h1;
                end
                // Presses that began inside the menu never reset alarms
                if (in_menu || long_press) begin
                    press_used <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Menu screens
    // ----------------------------------------------------------------
    assign idle_timeout = in_menu && (idle_count >= IDLE_CYCLES - 40'd1);   // [R17]
    assign menu_exit    = in_menu && (next_screen == S_NORMAL);

    always @* begin
        next_screen = screen;
        case (screen)
            S_NORMAL: begin
                if (long_press) begin
                    next_screen = S_LATCH1;
                end
            end
            S_LATCH1: begin
                if (menu_edge) begin
                    next_screen = S_LATCH2;                               // [R09]
                end
            end
            S_LATCH2: begin
                if (menu_edge) begin
                    next_screen = S_FS1;
                end
            end
            S_FS1: begin
                if (menu_edge) begin
                    next_screen = S_FS2;
                end
            end
            S_FS2: begin
                if (menu_edge) begin
                    next_screen = S_FAULT_FS;
                end
            end
            S_FAULT_FS: begin
                if (menu_edge) begin
                    next_screen = S_CAL;
                end
            end
            S_CAL: begin
                if (menu_edge) begin
                    next_screen = S_NORMAL;
                end
            end
            default: begin
                next_screen = S_NORMAL;
            end
        endcase
        if (idle_timeout) begin
            next_screen = S_NORMAL;                                       // [R17]
        end
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            screen        <= S_NORMAL;
            menu_active_o <= 1'b0;
            idle_count    <= 40'h0;
            inhibit_count <= 40'h0;
        end else begin
            screen        <= next_screen;
            menu_active_o <= (next_screen != S_NORMAL);
            if (!in_menu || any_edge) begin
                idle_count <= 40'h0;
            end else begin
                idle_count <= idle_count + 40'h1;
            end
            // Held at full while in the menu, runs down after leaving it
            if (in_menu) begin
                inhibit_count <= INHIBIT_CYCLES;                          // [R06]
            end else if (inhibit_count != 40'h0) begin
                inhibit_count <= inhibit_count - 40'h1;
            end
        end
    end

    assign inhibit = in_menu || (inhibit_count != 40'h0);                 // [R06]

    // ----------------------------------------------------------------
    // Configuration
    // ----------------------------------------------------------------
    assign bus_req   = wb_cyc_i & wb_stb_i;
    assign bus_write = bus_req & wb_we_i & wb_ack_o;

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            config_bits <= `CFG_RESET;                                    // [R03] [R12] [R13] [R14]
            cal_target  <= 16'h0000;
        end else begin
            case (screen)
                S_LATCH1: begin
                    if (add_edge || sub_edge) begin
                        config_bits[`CFG_LATCH1] <= ~config_bits[`CFG_LATCH1];   // [R08]
                    end
                end
                S_LATCH2: begin
                    if (add_edge || sub_edge) begin
                        config_bits[`CFG_LATCH2] <= ~config_bits[`CFG_LATCH2];   // [R08]
                    end
                end
                S_FS1: begin
                    if (add_edge) begin
                        config_bits[`CFG_FAILSAFE1] <= 1'b1;              // [R12]
                    end else if (sub_edge) begin
                        config_bits[`CFG_FAILSAFE1] <= 1'b0;              // [R12]
                    end
                end
                S_FS2: begin
                    if (add_edge) begin
                        config_bits[`CFG_FAILSAFE2] <= 1'b1;              // [R12]
                    end else if (sub_edge) begin
                        config_bits[`CFG_FAILSAFE2] <= 1'b0;              // [R12]
                    end
                end
                S_FAULT_FS: begin
                    if (add_edge) begin
                        config_bits[`CFG_FAULT_FS] <= 1'b1;               // [R13]
                    end else if (sub_edge) begin
                        config_bits[`CFG_FAULT_FS] <= 1'b0;               // [R13]
                    end
                end
                S_CAL: begin
                    if (add_edge) begin
                        config_bits[`CFG_CAL_AUTO] <= 1'b0;               // [R14]
                    end else if (sub_edge) begin
                        config_bits[`CFG_CAL_AUTO] <= 1'b1;               // [R14]
                    end
                end
                default: begin
                end
            endcase
            // Software write wins over a button in the same cycle
            if (bus_write && wb_adr_i == `REG_CONFIG && wb_sel_i[0]) begin
                config_bits <= wb_dat_i[`CFG_WIDTH-1:0];
            end
            if (bus_write && wb_adr_i == `REG_CAL_TARGET) begin
                if (wb_sel_i[0]) begin
                    cal_target[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    cal_target[15:8] <= wb_dat_i[15:8];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Relays and fault terminal
    // ----------------------------------------------------------------
    relay_channel u_relay1 (
        .clk_i        (clk_i),
        .reset_n_i    (reset_n_i),
        .reading_i    (gas_reading_i),
        .setpoint_i   (setpoint1_i),                                      // [R18]
        .latch_mode_i (config_bits[`CFG_LATCH1]),
        .fail_safe_i  (config_bits[`CFG_FAILSAFE1]),
        .inhibit_i    (inhibit),
        .op_reset_i   (op_reset),
        .alarm_o      (alarm1),
        .coil_o       (relay1_o)
    );

    relay_channel u_relay2 (
        .clk_i        (clk_i),
        .reset_n_i    (reset_n_i),
        .reading_i    (gas_reading_i),
        .setpoint_i   (setpoint2_i),                                      // [R18]
        .latch_mode_i (config_bits[`CFG_LATCH2]),
        .fail_safe_i  (config_bits[`CFG_FAILSAFE2]),
        .inhibit_i    (inhibit),
        .op_reset_i   (op_reset),
        .alarm_o      (alarm2),
        .coil_o       (relay2_o)
    );

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fault_term_o <= 1'b0;
        end else begin
            // Fail-safe yes: output asserted while healthy, dropped on fault
            fault_term_o <= config_bits[`CFG_FAULT_FS] ? ~fault_i : fault_i;   // [R13] [R19]
        end
    end

    // ----------------------------------------------------------------
    // Automatic calibration
    // ----------------------------------------------------------------
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cal_count   <= 40'h0;
            cal_force_o <= 1'b0;
            cal_value_o <= 16'h0000;
        end else begin
            cal_value_o <= cal_target;
            if (!cal_active_i || !config_bits[`CFG_CAL_AUTO]) begin
                cal_count   <= 40'h0;
                cal_force_o <= 1'b0;
            end else if (cal_count >= AUTOCAL_CYCLES - 40'd1) begin
                cal_force_o <= 1'b1;                                      // [R15]
            end else begin
                cal_count <= cal_count + 40'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    assign events = {cal_force_o & ~cal_force_prev,
                     menu_exit,
                     long_press,
                     fault_i & ~fault_prev,
                     alarm2 & ~alarm2_prev,
                     alarm1 & ~alarm1_prev};

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            alarm1_prev    <= 1'b0;
            alarm2_prev    <= 1'b0;
            fault_prev     <= 1'b0;
            cal_force_prev <= 1'b0;
            irq_status     <= {`EV_WIDTH{1'b0}};
            irq_enable     <= {`EV_WIDTH{1'b0}};
            irq_o          <= 1'b0;
        end else begin
            alarm1_prev    <= alarm1;
            alarm2_prev    <= alarm2;
            fault_prev     <= fault_i;
            cal_force_prev <= cal_force_o;
            // A new event beats a clear landing in the same cycle
            if (bus_write && wb_adr_i == `REG_IRQ_CLEAR && wb_sel_i[0]) begin
                irq_status <= (irq_status & ~wb_dat_i[`EV_WIDTH-1:0]) | events;
            end else begin
                irq_status <= irq_status | events;
            end
            if (bus_write && wb_adr_i == `REG_IRQ_ENABLE && wb_sel_i[0]) begin
                irq_enable <= wb_dat_i[`EV_WIDTH-1:0];
            end
            irq_o <= |(irq_status & irq_enable);
        end
    end

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            wb_dat_o <= 32'h00000000;
            if (bus_req && !wb_ack_o && !wb_we_i) begin
                case (wb_adr_i)
                    `REG_CONFIG:     wb_dat_o <= {26'h0, config_bits};
                    `REG_STATE:      wb_dat_o <= {24'h0, screen, inhibit, relay2_o, relay1_o, alarm2, alarm1};
                    `REG_IRQ_STATUS: wb_dat_o <= {26'h0, irq_status};
                    `REG_IRQ_ENABLE: wb_dat_o <= {26'h0, irq_enable};
                    `REG_CAL_TARGET: wb_dat_o <= {16'h0, cal_target};
                    default:         wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // alarm_relay_control

/* File: hdl/relay_channel.v */
// One alarm relay: trip, hysteresis release, latching and fail-safe drive
`timescale 1ns/100ps
`include "alarm_defs.vh"

module relay_channel (
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire [15:0] reading_i,
    input  wire [15:0] setpoint_i,
    input  wire        latch_mode_i,
    input  wire        fail_safe_i,
    input  wire        inhibit_i,
    input  wire        op_reset_i,
    output reg         alarm_o,
    output reg         coil_o
);

    wire [15:0] release_level;
    wire        over_setpoint;
    wire        below_setpoint;
    wire        below_release;
    reg         next_alarm;

    // Release point sits 10 percent under the trip level
    assign release_level  = setpoint_i - (setpoint_i / 16'd10);   // [R04]
    assign over_setpoint  = (reading_i >= setpoint_i);            // [R18]
    assign below_setpoint = (reading_i < setpoint_i);
    assign below_release  = (reading_i < release_level);

    always @* begin
        next_alarm = alarm_o;
        if (!alarm_o) begin
            if (over_setpoint && !inhibit_i) begin                // [R06]
                next_alarm = 1'b1;
            end
        end else if (latch_mode_i) begin
            if (op_reset_i && below_setpoint) begin               // [R02] [R05]
                next_alarm = 1'b0;
            end
        end else if (below_release) begin                         // [R01] [R04]
            next_alarm = 1'b0;
        end
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            alarm_o <= 1'b0;
            coil_o  <= 1'b0;
        end else begin
            alarm_o <= next_alarm;
            // Fail-safe: energised when quiet, dropped on alarm
            coil_o  <= next_alarm ^ fail_safe_i;                  // [R10] [R11]
        end
    end

endmodule // relay_channel

/* File: include/alarm_defs.vh */
// Constants for the alarm relay control block: timing, register map, field layout, reset values
`ifndef ALARM_DEFS_VH
`define ALARM_DEFS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ             40'd200000000
`define INHIBIT_TIME_S     40'd60
`define LONG_PRESS_TIME_S  40'd6
`define IDLE_TIME_S        40'd300
`define AUTOCAL_TIME_S     40'd30
`define INHIBIT_CYCLES     (`INHIBIT_TIME_S * `CLK_HZ)
`define LONG_PRESS_CYCLES  (`LONG_PRESS_TIME_S * `CLK_HZ)
`define IDLE_CYCLES        (`IDLE_TIME_S * `CLK_HZ)
`define AUTOCAL_CYCLES     (`AUTOCAL_TIME_S * `CLK_HZ)

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define REG_CONFIG         6'h00
`define REG_STATE          6'h04
`define REG_IRQ_STATUS     6'h08
`define REG_IRQ_CLEAR      6'h0C
`define REG_IRQ_ENABLE     6'h10
`define REG_CAL_TARGET     6'h14

// ----------------------------------------------------------------
// Config fields
// ----------------------------------------------------------------
`define CFG_LATCH1         0
`define CFG_LATCH2         1
`define CFG_FAILSAFE1      2
`define CFG_FAILSAFE2      3
`define CFG_FAULT_FS       4
`define CFG_CAL_AUTO       5
`define CFG_WIDTH          6
`define CFG_RESET          6'h10

// ----------------------------------------------------------------
// Interrupt events
// ----------------------------------------------------------------
`define EV_TRIP1           0
`define EV_TRIP2           1
`define EV_FAULT           2
`define EV_MENU_ENTER      3
`define EV_MENU_EXIT       4
`define EV_AUTOCAL         5
`define EV_WIDTH           6

`endif

/* File: testbench/alarm_relay_sva.sv */
// Port-level assertions for the alarm relay control block
`timescale 1ns/100ps
module alarm_relay_sva #(
    parameter [39:0] LONG_PRESS_CYCLES = 40'h14,
    parameter [39:0] IDLE_CYCLES       = 40'hC8
) (
    input logic        clk_i,
    input logic        reset_n_i,
    input logic        add_btn_i,
    input logic        sub_btn_i,
    input logic        menu_btn_i,
    input logic        fault_i,
    input logic        cal_active_i,
    input logic        relay1_o,
    input logic        relay2_o,
    input logic        fault_term_o,
    input logic        cal_force_o,
    input logic [15:0] cal_value_o,
    input logic        menu_active_o,
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic        wb_we_i,
    input logic [5:0]  wb_adr_i,
    input logic [31:0] wb_dat_i,
    input logic        wb_ack_o
);
    logic [39:0] hold_cnt;
    logic [39:0] idle_cnt;
    // Quiet count starts at release, so it lags the design timer
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hold_cnt <= 40'h0;
            idle_cnt <= 40'h0;
        end else begin
            hold_cnt <= menu_btn_i ? hold_cnt + 40'h1 : 40'h0;
            idle_cnt <= (add_btn_i | sub_btn_i | menu_btn_i) ? 40'h0 : idle_cnt + 40'h1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ack too long");
    property p_start; $rose(reset_n_i) |=> !relay1_o && !relay2_o; endproperty
    a_start: assert property (p_start) else $error("relay on at start");
    property p_fault; $changed(fault_i) && !wb_cyc_i && !menu_active_o |=> $changed(fault_term_o); endproperty
    a_fault: assert property (p_fault) else $error("fault line stuck");
    property p_long; !menu_active_o && hold_cnt == LONG_PRESS_CYCLES - 40'h1 |-> ##[0:3] menu_active_o; endproperty
    a_long: assert property (p_long) else $error("menu not opened");
    property p_idle; idle_cnt == IDLE_CYCLES + 40'h4 |-> !menu_active_o; endproperty
    a_idle: assert property (p_idle) else $error("menu not left");
    property p_force; cal_force_o |-> $past(cal_active_i); endproperty
    a_force: assert property (p_force) else $error("force outside cal");
    property p_target; wb_ack_o && wb_we_i && wb_adr_i == 6'h14 |-> ##2 cal_value_o == $past(wb_dat_i[15:0], 2);
    endproperty
    a_target: assert property (p_target) else $error("target not copied");
    c_menu: cover property (menu_active_o);
    c_force: cover property (cal_force_o);
    c_release: cover property ($fell(relay2_o));
endmodule // alarm_relay_sva
bind alarm_relay_control alarm_relay_sva #(.LONG_PRESS_CYCLES(LONG_PRESS_CYCLES), .IDLE_CYCLES(IDLE_CYCLES))
    alarm_relay_sva_i (.*);

/* File: testbench/alarm_wiring.sv */
// Controller-side view of the relay 1 contact and fault line
`timescale 1ns/100ps
module alarm_wiring (
    input  logic relay1_i,
    input  logic fs1_i,
    input  logic fault_term_i,
    output logic alarm1_seen_o,
    output logic fault_seen_o
);
    // Fail-safe wiring reads a dropped coil as a hazard
    assign alarm1_seen_o = relay1_i ^ fs1_i;
    assign fault_seen_o  = ~fault_term_i;
endmodule // alarm_wiring

/* File: testbench/tb.sv */
// Self-checking bench for the alarm relay control block
`timescale 1ns/100ps
module tb;
    logic        clk_i = 0, reset_n_i = 0, fault_i = 0, cal_i = 0, cyc = 0, we = 0, fs1 = 0;
    logic [2:0]  btn = 3'h0;
    logic [5:0]  adr = 6'h0;
    logic [15:0] gas = 16'h0, sp1 = 16'h64, sp2 = 16'h78;
    logic [31:0] dat = 32'h0, q;
    wire         relay1, relay2, fterm, cforce, menu, irq, ack, seen1, fseen;
    wire  [15:0] cval;
    wire  [31:0] rdat;
    integer      num_errors = 0, check_count = 0;
    alarm_relay_control #(.INHIBIT_CYCLES(40'h28), .LONG_PRESS_CYCLES(40'h14), .IDLE_CYCLES(40'hC8),
        .AUTOCAL_CYCLES(40'h1E)) alarm_relay_control_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .gas_reading_i(gas), .setpoint1_i(sp1), .setpoint2_i(sp2), .add_btn_i(btn[0]), .sub_btn_i(btn[1]),
        .menu_btn_i(btn[2]), .fault_i(fault_i), .cal_active_i(cal_i), .relay1_o(relay1), .relay2_o(relay2),
        .fault_term_o(fterm), .cal_force_o(cforce), .cal_value_o(cval), .menu_active_o(menu), .irq_o(irq),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack));
    alarm_wiring alarm_wiring_i (.relay1_i(relay1), .fs1_i(fs1), .fault_term_i(fterm),
        .alarm1_seen_o(seen1), .fault_seen_o(fseen));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task final_report;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, s, e);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    // Classic cycle, bounded ack wait
    task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        integer n;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            n++;
            if (n > 20) begin
                num_errors++;
                final_report;
            end
            @(posedge clk_i);
        end
        q = rdat;
        cyc <= 1'b0;
    endtask
    task rd(input logic [5:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task push(input logic [2:0] b, input integer n);
        @(posedge clk_i);
        btn <= b;
        tick(n);
        btn <= 3'h0;
        tick(4);
    endtask
    task level(input logic [15:0] v);
        @(posedge clk_i);
        gas <= v;
        tick(3);
    endtask
    initial begin
        tick(10);
        reset_n_i <= 1'b1;
        rd(6'h00, 32'h10);
        rd(6'h3C, 32'h0);
        wb(1'b1, 6'h10, 32'h8);
        fault_i <= 1'b1;
        tick(3);
        chk(fterm, 0);
        chk(fseen, 1);
        chk(irq, 0);
        wb(1'b1, 6'h00, 32'h0);
        tick(3);
        chk(fterm, 1);
        $display("fault terminal done");
        level(16'h64);
        chk({relay1, relay2}, 2);
        level(16'h5A);
        chk(relay1, 1);
        level(16'h59);
        chk(relay1, 0);
        $display("auto reset done");
        push(3'h4, 25);
        chk(menu, 1);
        chk(irq, 1);
        wb(1'b1, 6'h0C, 32'h8);
        tick(2);
        chk(irq, 0);
        rd(6'h08, 32'h5);
        push(3'h1, 2);
        rd(6'h00, 32'h1);
        push(3'h4, 2);
        push(3'h2, 2);
        rd(6'h00, 32'h3);
        push(3'h4, 2);
        push(3'h1, 2);
        repeat (3) push(3'h4, 2);
        push(3'h1, 2);
        rd(6'h00, 32'h7);
        push(3'h2, 2);
        rd(6'h00, 32'h27);
        push(3'h4, 2);
        chk(menu, 0);
        fs1 <= 1'b1;
        chk(relay1, 1);
        $display("menu done");
        level(16'h96);
        chk({relay1, relay2}, 2);
        tick(45);
        chk({relay1, relay2}, 1);
        chk(seen1, 1);
        level(16'h32);
        chk({relay1, relay2}, 1);
        level(16'h6E);
        push(3'h4, 3);
        chk({relay1, relay2}, 0);
        level(16'h32);
        push(3'h4, 3);
        chk(relay1, 1);
        $display("latching done");
        wb(1'b1, 6'h14, 32'h1234);
        tick(2);
        chk(cval, 32'h1234);
        cal_i <= 1'b1;
        tick(20);
        chk(cforce, 0);
        tick(15);
        chk(cforce, 1);
        cal_i <= 1'b0;
        tick(2);
        chk(cforce, 0);
        $display("auto cal done");
        push(3'h4, 25);
        tick(150);
        chk(menu, 1);
        tick(60);
        chk(menu, 0);
        $display("idle exit done");
        final_report;
    end
endmodule // tb
